/* hdl/hpcd_pkg.sv */
/*
 package for the host port cycle decoder: widths, register layout,
 reset values, cycle type codes and the structs passed between processes.
 assumes nothing of its surroundings beyond a synthesis tool that takes packed structs.
*/
package hpcd_pkg;

   // ------------------------------------------------------------------
   // widths
   // ------------------------------------------------------------------
   localparam int HALF_W = 16;                   // host data bus width
   localparam int WORD_W = 32;                   // assembled word width

   // ------------------------------------------------------------------
   // control register layout and reset values
   // ------------------------------------------------------------------
   localparam int CTRL_ORDER_BIT = 0;            // writable order field
   localparam int CTRL_ORDER_RB_BIT = 8;         // read-only copy of order
   localparam logic CTRL_ORDER_RESET = 1'b0;     // first halfword most significant
   localparam logic [WORD_W-1:0] ADDR_RESET = 32'h00000000;
   localparam logic [WORD_W-1:0] DATA_RESET = 32'h00000000;
   localparam logic [WORD_W-1:0] ADDR_STEP = 32'h00000001;   // post-increment step
   localparam logic [HALF_W-1:0] HALF_ZERO = 16'h0000;

   // ------------------------------------------------------------------
   // access type codes and the eight cycle types
   // ------------------------------------------------------------------
   localparam logic [1:0] SEL_CTRL = 2'h0;       // control register
   localparam logic [1:0] SEL_DATA_INC = 2'h1;   // data, post-increment
   localparam logic [1:0] SEL_ADDR = 2'h2;       // address register
   localparam logic [1:0] SEL_DATA = 2'h3;       // data, no increment

   typedef enum logic [2:0] {
      CYC_CTRL_WR = 3'b000,
      CYC_CTRL_RD = 3'b001,
      CYC_DINC_WR = 3'b010,
      CYC_DINC_RD = 3'b011,
      CYC_ADDR_WR = 3'b100,
      CYC_ADDR_RD = 3'b101,
      CYC_DATA_WR = 3'b110,
      CYC_DATA_RD = 3'b111
   } hpcd_cycle_t;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic cs_n;                      // chip select, active low
      logic ds_a;                      // data strobe a
      logic ds_b;                      // data strobe b
      logic [1:0] sel;                 // access type select
      logic rnw;                       // read high, write low
      logic second;                    // halfword identifier
      logic [HALF_W-1:0] data;         // host data bus input
   } hpcd_pins_t;

   typedef struct packed {
      logic [1:0] sel;
      logic rnw;
      logic second;
   } hpcd_latch_t;

   typedef struct packed {
      logic write;                     // 1 write to memory, 0 read
      logic [WORD_W-1:0] addr;         // memory word address
      logic [WORD_W-1:0] data;         // write data
   } hpcd_mem_req_t;

   localparam hpcd_pins_t PINS_RESET = '{cs_n: 1'b1, ds_a: 1'b0, ds_b: 1'b0,
      sel: 2'h0, rnw: 1'b0, second: 1'b0, data: 16'h0000};
   localparam hpcd_latch_t LATCH_RESET = '{sel: 2'h0, rnw: 1'b0, second: 1'b0};
   localparam hpcd_mem_req_t MEM_REQ_RESET = '{write: 1'b0, addr: 32'h00000000,
      data: 32'h00000000};

endpackage

/* hdl/hpcd_top.sv */
/*
 host port cycle decoder: synchronises the host pins, forms the internal
 strobe, latches the cycle type and starts reads at its fall, executes writes at its
 rise, pairs halfwords into words and issues memory requests.
 assumes a memory side on ref_clk that answers each read request with
 mem_rd_valid and accepts write requests as one-cycle pulses.
*/
`timescale 1ns/100ps
`default_nettype none

module hpcd_top (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic port_chip_select_n,
   input wire logic data_strobe_a,
   input wire logic data_strobe_b,
   input wire logic [1:0] access_type_sel,
   input wire logic host_read_not_write,
   input wire logic halfword_second_flag,
   input wire logic [hpcd_pkg::HALF_W-1:0] host_data_bus_in,
   output logic [hpcd_pkg::HALF_W-1:0] host_data_bus_out,
   output logic host_data_bus_oe,
   output logic port_ready,
   output logic halfword_order_bit,
   output hpcd_pkg::hpcd_mem_req_t mem_req,
   output logic mem_req_valid,
   input wire logic mem_rd_valid,
   input wire logic [hpcd_pkg::WORD_W-1:0] mem_rd_data
);
   import hpcd_pkg::*;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // place a halfword into the upper or lower half of a word
   function automatic logic [WORD_W-1:0] put_half(input logic [WORD_W-1:0] w,
         input logic [HALF_W-1:0] h, input logic upper);
      logic [WORD_W-1:0] r;
      r = w;
      if (upper) begin
         r[WORD_W-1:HALF_W] = h;
      end else begin
         r[HALF_W-1:0] = h;
      end
      return r;
   endfunction

   // pick the upper or lower halfword of a word
   function automatic logic [HALF_W-1:0] get_half(input logic [WORD_W-1:0] w,
         input logic upper);
      return upper ? w[WORD_W-1:HALF_W] : w[HALF_W-1:0];
   endfunction

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef enum logic {
      ST_IDLE = 1'b0,                 // waiting for a strobe fall
      ST_XFER = 1'b1                  // strobe low, transfer open
   } hpcd_state_t;

   hpcd_pins_t pins_raw;                   // pins gathered
   hpcd_pins_t sync1_reg;                  // first synchroniser stage
   hpcd_pins_t sync2_reg;                  // second synchroniser stage
   logic strb_n;                           // combined strobe, active low
   logic strb_n_prev_reg;                  // strobe one cycle ago
   logic strb_n_prev_next;
   logic strb_fall;                        // strobe went low
   logic strb_rise;                        // strobe went high
   hpcd_state_t state_reg, state_next;
   hpcd_latch_t lat_reg, lat_next;         // captured cycle type
   hpcd_cycle_t cyc_now;                   // type seen at the fall
   hpcd_cycle_t cyc_lat;                   // type of the open transfer
   logic order_reg, order_next;            // halfword order setting
   logic [WORD_W-1:0] raddr_reg, raddr_next;   // read address register
   logic [WORD_W-1:0] waddr_reg, waddr_next;   // write address register
   logic [WORD_W-1:0] data_reg, data_next;     // data register
   logic [HALF_W-1:0] out_reg, out_next;       // read data to the bus
   logic ready_reg, ready_next;            // internal ready, before gating
   hpcd_mem_req_t req_reg, req_next;
   logic req_vld_reg, req_vld_next;
   logic upper_now;                        // halfword position at fall
   logic upper_lat;                        // halfword position of open transfer
   logic [WORD_W-1:0] word_wr;             // data word with this halfword

   // ------------------------------------------------------------------
   // pin synchroniser and strobe forming
   // ------------------------------------------------------------------
   assign pins_raw = '{cs_n: port_chip_select_n, ds_a: data_strobe_a,
      ds_b: data_strobe_b, sel: access_type_sel, rnw: host_read_not_write,
      second: halfword_second_flag, data: host_data_bus_in};

   // strobes count only with chip select low; one strobe active of two
   assign strb_n = sync2_reg.cs_n | ~(sync2_reg.ds_a ^ sync2_reg.ds_b);
   assign strb_fall = strb_n_prev_reg & ~strb_n;
   assign strb_rise = ~strb_n_prev_reg & strb_n;

   // cycle type from select and direction
   assign cyc_now = hpcd_cycle_t'({sync2_reg.sel, sync2_reg.rnw});
   assign cyc_lat = hpcd_cycle_t'({lat_reg.sel, lat_reg.rnw});

   // order one: first halfword goes low; zero: first goes high
   assign upper_now = ~(sync2_reg.second ^ order_reg);
   assign upper_lat = ~(lat_reg.second ^ order_reg);
   assign word_wr = put_half(data_reg, sync2_reg.data, upper_lat);

   // ------------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------------
   always_comb begin
      strb_n_prev_next = strb_n;
      state_next = state_reg;
      lat_next = lat_reg;
      order_next = order_reg;
      raddr_next = raddr_reg;
      waddr_next = waddr_reg;
      data_next = data_reg;
      out_next = out_reg;
      ready_next = ready_reg;
      req_next = req_reg;
      req_vld_next = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            // latch the cycle type and start the access from it
            if (strb_fall) begin
               lat_next = '{sel: sync2_reg.sel, rnw: sync2_reg.rnw,
                  second: sync2_reg.second};
               state_next = ST_XFER;
               ready_next = 1'b1;
               case (cyc_now)
                  CYC_CTRL_RD: begin
                     // order visible at both bit positions, rest zero
                     out_next = HALF_ZERO;
                     out_next[CTRL_ORDER_BIT] = order_reg;
                     out_next[CTRL_ORDER_RB_BIT] = order_reg;
                  end
                  CYC_ADDR_RD: begin
                     out_next = get_half(raddr_reg, upper_now);
                  end
                  CYC_DINC_RD, CYC_DATA_RD: begin
                     if (!sync2_reg.second) begin
                        // first halfword fetches the word; wait for it
                        req_next = '{write: 1'b0, addr: raddr_reg, data: DATA_RESET};
                        req_vld_next = 1'b1;
                        ready_next = 1'b0;
                     end else begin
                        out_next = get_half(data_reg, upper_now);
                     end
                  end
                  default: begin
                     // writes act at the strobe rise
                     out_next = out_reg;
                  end
               endcase
            end
         end
         ST_XFER: begin
            // memory answer to a pending data read
            if (!ready_reg && mem_rd_valid) begin
               data_next = mem_rd_data;
               out_next = get_half(mem_rd_data, upper_lat);
               ready_next = 1'b1;
            end
            // rise ends the transfer; an early rise just closes it
            if (strb_rise) begin
               state_next = ST_IDLE;
               ready_next = 1'b1;
               case (cyc_lat)
                  CYC_CTRL_WR: begin
                     // flag ignored: every transfer writes the same register
                     order_next = sync2_reg.data[CTRL_ORDER_BIT];
                  end
                  CYC_ADDR_WR: begin
                     // single address mode: both registers follow
                     raddr_next = put_half(raddr_reg, sync2_reg.data, upper_lat);
                     waddr_next = put_half(waddr_reg, sync2_reg.data, upper_lat);
                  end
                  CYC_DINC_WR, CYC_DATA_WR: begin
                     data_next = word_wr;
                     // the second halfword completes the word
                     if (lat_reg.second) begin
                        req_next = '{write: 1'b1, addr: waddr_reg, data: word_wr};
                        req_vld_next = 1'b1;
                        if (lat_reg.sel == SEL_DATA_INC) begin
                           waddr_next = waddr_reg + ADDR_STEP;
                        end else begin
                           waddr_next = waddr_reg;
                        end
                     end
                  end
                  CYC_DINC_RD, CYC_DATA_RD: begin
                     // step the read address after the second halfword of an increment read
                     if (lat_reg.second && lat_reg.sel == SEL_DATA_INC) begin
                        raddr_next = raddr_reg + ADDR_STEP;
                     end else begin
                        raddr_next = raddr_reg;
                     end
                  end
                  default: begin
                     // control and address reads change nothing
                     raddr_next = raddr_reg;
                  end
               endcase
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         sync1_reg <= PINS_RESET;
         sync2_reg <= PINS_RESET;
         strb_n_prev_reg <= 1'b1;
         state_reg <= ST_IDLE;
         lat_reg <= LATCH_RESET;
         order_reg <= CTRL_ORDER_RESET;
         raddr_reg <= ADDR_RESET;
         waddr_reg <= ADDR_RESET;
         data_reg <= DATA_RESET;
         out_reg <= HALF_ZERO;
         ready_reg <= 1'b1;
         req_reg <= MEM_REQ_RESET;
         req_vld_reg <= 1'b0;
      end else begin
         sync1_reg <= pins_raw;
         sync2_reg <= sync1_reg;
         strb_n_prev_reg <= strb_n_prev_next;
         state_reg <= state_next;
         lat_reg <= lat_next;
         order_reg <= order_next;
         raddr_reg <= raddr_next;
         waddr_reg <= waddr_next;
         data_reg <= data_next;
         out_reg <= out_next;
         ready_reg <= ready_next;
         req_reg <= req_next;
         req_vld_reg <= req_vld_next;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   // ready dropped whenever the synchronised chip select (second stage) is high
   assign port_ready = ready_reg & ~sync2_reg.cs_n;
   // drive the bus only during an open read transfer
   assign host_data_bus_oe = (state_reg == ST_XFER) & lat_reg.rnw & ~strb_n;
   assign host_data_bus_out = out_reg;
   assign halfword_order_bit = order_reg;
   assign mem_req = req_reg;
   assign mem_req_valid = req_vld_reg;

endmodule // hpcd_top

`default_nettype wire

/* testbench/hpcd_chk_props.sv */
/*
 checker for the host port cycle decoder: watches the top ports only.
 assumes the host holds select and direction from before the strobe
 falls until the strobe has been high for several cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module hpcd_chk (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic port_chip_select_n,
   input wire logic [1:0] access_type_sel,
   input wire logic host_read_not_write,
   input wire logic host_data_bus_oe,
   input wire logic port_ready,
   input wire logic halfword_order_bit,
   input wire hpcd_pkg::hpcd_mem_req_t mem_req,
   input wire logic mem_req_valid,
   input wire logic mem_rd_valid
);
   import hpcd_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // chip select seen low for three samples
   sequence cs_held_low; !port_chip_select_n [*3]; endsequence
   // memory fetch for a first read halfword
   sequence read_fetch; mem_req_valid && !mem_req.write; endsequence
   ready_cs_gate_a: assert property (port_chip_select_n [*3] |-> !port_ready)
      else $error("ready high while deselected");
   oe_cs_gate_a: assert property (port_chip_select_n [*4] |-> !host_data_bus_oe)
      else $error("bus driven while deselected");
   rd_req_wait_a: assert property (read_fetch |-> !port_ready)
      else $error("ready high while fetching");
   rd_answer_a: assert property (cs_held_low ##0 mem_rd_valid |-> ##[1:2] port_ready)
      else $error("ready missing after fetch");
   req_pulse_a: assert property (mem_req_valid |=> !mem_req_valid)
      else $error("request longer than one cycle");
   rd_req_kind_a: assert property (read_fetch |->
      $past(host_read_not_write, 3) && $past(access_type_sel[0], 3))
      else $error("fetch outside a data read");
   wr_req_kind_a: assert property (mem_req_valid && mem_req.write |->
      !$past(host_read_not_write, 3) && $past(access_type_sel[0], 3))
      else $error("store outside a data write");
   oe_read_only_a: assert property ($rose(host_data_bus_oe) |->
      $past(host_read_not_write, 2))
      else $error("bus driven in a write");
   order_write_a: assert property ($changed(halfword_order_bit) |->
      $past(access_type_sel, 4) == SEL_CTRL && !$past(host_read_not_write, 4))
      else $error("order changed without control write");
endmodule // hpcd_chk
`default_nettype wire

/* testbench/hpcd_mem_model.sv */
/*
 word memory behind the decoder: stores writes, answers reads after LAT cycles.
 assumes one outstanding read at a time.
*/
`timescale 1ns/100ps
`default_nettype none
module hpcd_mem_model #(
   parameter logic [2:0] LAT = 3'h3
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire hpcd_pkg::hpcd_mem_req_t mem_req,
   input wire logic mem_req_valid,
   output logic mem_rd_valid,
   output logic [hpcd_pkg::WORD_W-1:0] mem_rd_data
);
   logic [31:0] mem [16];   // sixteen words, address wraps
   logic [2:0] wait_reg;    // cycles left before the answer
   logic [3:0] rd_addr;     // address of the pending read
   // outside an answer the data lines invert every cycle instead of holding the last answer
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         wait_reg <= 3'h0;
         mem_rd_valid <= 1'b0;
         mem_rd_data <= 32'h00000000;
      end else begin
         mem_rd_valid <= (wait_reg == 3'h1);
         mem_rd_data <= (wait_reg == 3'h1) ? mem[rd_addr] : ~mem_rd_data;
         if (wait_reg != 3'h0) wait_reg <= wait_reg - 3'h1;
         if (mem_req_valid && mem_req.write) mem[mem_req.addr[3:0]] <= mem_req.data;
         if (mem_req_valid && !mem_req.write) begin
            wait_reg <= LAT;
            rd_addr <= mem_req.addr[3:0];
         end
      end
   end
endmodule // hpcd_mem_model
`default_nettype wire

/* testbench/testbench.sv */
/*
 testbench for the host port cycle decoder: plays the host, checks words.
 assumes the memory model and the checker from this folder.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
   import hpcd_pkg::*;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   hpcd_pins_t pins = PINS_RESET;   // host pins
   logic [15:0] dout;
   logic oe, rdy, ord, req_v, rd_v, ord_tb = 1'b0;
   logic [31:0] rd_d, rword;
   hpcd_mem_req_t req;
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   hpcd_top i_dut (.ref_clk(ref_clk), .nrst(nrst), .port_chip_select_n(pins.cs_n),
      .data_strobe_a(pins.ds_a), .data_strobe_b(pins.ds_b), .access_type_sel(pins.sel),
      .host_read_not_write(pins.rnw), .halfword_second_flag(pins.second),
      .host_data_bus_in(pins.data), .host_data_bus_out(dout), .host_data_bus_oe(oe),
      .port_ready(rdy), .halfword_order_bit(ord), .mem_req(req), .mem_req_valid(req_v),
      .mem_rd_valid(rd_v), .mem_rd_data(rd_d));
   hpcd_mem_model #(.LAT(3'h4)) i_mem (.ref_clk(ref_clk), .nrst(nrst), .mem_req(req),
      .mem_req_valid(req_v), .mem_rd_valid(rd_v), .mem_rd_data(rd_d));
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   // one halfword transfer; the strobe rises once ready is seen, or after 50 more cycles without it
   task automatic xfer(input logic [1:0] sel, input logic rnw, input logic sec,
      input logic [15:0] din, output logic [15:0] q);
      int n;
      n = 0;
      @(posedge ref_clk);
      pins <= '{cs_n: 1'b0, ds_a: 1'b0, ds_b: 1'b0, sel: sel, rnw: rnw, second: sec, data: din};
      repeat (2) @(posedge ref_clk);
      // reads strobe on one pin, writes on the other
      if (rnw) begin
         pins.ds_b <= 1'b1;
      end else begin
         pins.ds_a <= 1'b1;
      end
      repeat (6) @(negedge ref_clk);
      while (rdy !== 1'b1 && n < 50) begin
         @(negedge ref_clk);
         n++;
      end
      q = dout;
      `CHK(oe, rnw)
      @(posedge ref_clk);
      pins.ds_a <= 1'b0;
      pins.ds_b <= 1'b0;
      repeat (5) @(posedge ref_clk);
      if (n >= 50) err_total++;
   endtask
   // two halfwords, flag low then high, ordered by the order bit
   task automatic word(input logic [1:0] sel, input logic rnw, input logic [31:0] w,
      output logic [31:0] r);
      logic [15:0] a, b;
      xfer(sel, rnw, 1'b0, ord_tb ? w[15:0] : w[31:16], a);
      xfer(sel, rnw, 1'b1, ord_tb ? w[31:16] : w[15:0], b);
      r = ord_tb ? {b, a} : {a, b};
   endtask
   task automatic s_ctrl();
      logic [15:0] q;
      xfer(SEL_CTRL, 1'b0, 1'b1, 16'hFF01, q);
      `CHK(ord, 1'b1)
      xfer(SEL_CTRL, 1'b1, 1'b0, 16'h0000, q);
      `CHK(q, 16'h0101)
      xfer(SEL_CTRL, 1'b0, 1'b0, 16'hFFFE, q);
      xfer(SEL_CTRL, 1'b1, 1'b1, 16'h0000, q);
      `CHK(q, 16'h0000)
   endtask
   task automatic s_data(input logic o);
      logic [15:0] q;
      logic [31:0] base;
      base = o ? 32'h5A6B7C8D : 32'hA1B2C3D4;
      xfer(SEL_CTRL, 1'b0, 1'b0, {15'h0000, o}, q);
      ord_tb = o;
      word(SEL_ADDR, 1'b0, 32'h00000005, rword);
      // address read gives back the word just written
      word(SEL_ADDR, 1'b1, 32'h00000000, rword);
      `CHK(rword, 32'h00000005)
      word(SEL_DATA, 1'b0, base, rword);
      `CHK(i_mem.mem[5], base)
      repeat (2) begin
         word(SEL_DATA, 1'b1, 32'h00000000, rword);
         `CHK(rword, base)
      end
      word(SEL_ADDR, 1'b0, 32'h00000008, rword);
      word(SEL_DATA_INC, 1'b0, ~base, rword);
      word(SEL_DATA_INC, 1'b0, {base[15:0], base[31:16]}, rword);
      `CHK(i_mem.mem[8], ~base)
      `CHK(i_mem.mem[9], {base[15:0], base[31:16]})
      word(SEL_ADDR, 1'b0, 32'h00000008, rword);
      word(SEL_DATA_INC, 1'b1, 32'h00000000, rword);
      `CHK(rword, ~base)
      word(SEL_DATA_INC, 1'b1, 32'h00000000, rword);
      `CHK(rword, {base[15:0], base[31:16]})
      // two stepped reads leave the read address two words on
      word(SEL_ADDR, 1'b1, 32'h00000000, rword);
      `CHK(rword, 32'h0000000A)
   endtask
   // strobes with chip select high must change nothing
   task automatic s_cs();
      @(posedge ref_clk);
      pins <= '{cs_n: 1'b1, ds_a: 1'b0, ds_b: 1'b0, sel: SEL_CTRL, rnw: 1'b0,
         second: 1'b0, data: {15'h0000, ~ord_tb}};
      repeat (2) begin
         repeat (5) @(posedge ref_clk);
         pins.ds_b <= 1'b1;
         repeat (5) @(posedge ref_clk);
         pins.ds_b <= 1'b0;
      end
      @(negedge ref_clk);
      `CHK(rdy, 1'b0)
      `CHK(ord, ord_tb)
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(negedge ref_clk);
      `CHK(ord, CTRL_ORDER_RESET)
      `CHK(rdy, 1'b0)
      s_ctrl();
      s_data(1'b0);
      s_data(1'b1);
      s_cs();
      tally_and_finish();
   end
endmodule // testbench
bind hpcd_top hpcd_chk i_chk (.ref_clk, .nrst, .port_chip_select_n, .access_type_sel,
   .host_read_not_write, .host_data_bus_oe, .port_ready, .halfword_order_bit, .mem_req,
   .mem_req_valid, .mem_rd_valid);
`default_nettype wire
